// *** src/gpio_half.sv ***
// upper pin half: bus data or general-purpose port, chosen by the strap
`timescale 1ns/100ps
module gpio_half (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  // mode
  input  wire logic                        wide_mode,
  // bus side
  input  wire logic [sysbus_pkg::HALF_W-1:0] bus_out,
  input  wire logic                        bus_oe,
  // user port side
  input  wire logic [sysbus_pkg::HALF_W-1:0] gpio_out,
  input  wire logic [sysbus_pkg::HALF_W-1:0] gpio_dir,
  // pins
  output logic      [sysbus_pkg::HALF_W-1:0] pin_out,
  output logic      [sysbus_pkg::HALF_W-1:0] pin_oe
);

  typedef struct packed {
    logic [sysbus_pkg::HALF_W-1:0] out;
    logic [sysbus_pkg::HALF_W-1:0] oe;
  } half_state_type;

  half_state_type                  st_r;
  half_state_type                  st_nxt;
  wire logic [sysbus_pkg::HALF_W-1:0] sel_out;
  wire logic [sysbus_pkg::HALF_W-1:0] sel_oe;

  // per-pin selection between bus data and port drive
  genvar i;
  generate
    for (i = 0; i < sysbus_pkg::HALF_W; i++) begin : g_pin
      assign sel_out[i] = wide_mode ? bus_out[i] : gpio_out[i];
      assign sel_oe[i]  = wide_mode ? bus_oe : gpio_dir[i];
    end
  endgenerate

  // record filled in one process so no bit has two writers
  always_comb begin
    st_nxt.out = sel_out;
    st_nxt.oe  = sel_oe;
  end

  // registered pins, frozen while the enable is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign pin_out = st_r.out;
  assign pin_oe  = st_r.oe;

endmodule : gpio_half

// *** src/sysbus_pkg.sv ***
// shared constants and types for the parallel system bus port
package sysbus_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 26;
  localparam int HALF_W = 16;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // target encodings on the request port
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TGT_DRAM = 2'h0,
    TGT_ROM  = 2'h1,
    TGT_LCD  = 2'h2,
    TGT_ISA  = 2'h3
  } target_type;

  // ----------------------------------------------------------------
  // timing counts: strobe length for non-panel targets
  // ----------------------------------------------------------------
  localparam int         STROBE_NS     = 8;
  localparam int         CLK_PERIOD_NS = 4;
  localparam logic [3:0] STROBE_CYC    = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 26'h000_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [HALF_W-1:0] HALF_RST = 16'h0000;

  // ----------------------------------------------------------------
  // access sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_STROBE = 4'b0010,
    ST_PANEL  = 4'b0100,
    ST_DONE   = 4'b1000
  } state_type;

endpackage : sysbus_pkg

// *** src/system_bus_lcd_mem_port.sv ***
// processor-side parallel system bus port for dram, rom, panel and isa targets
//
// Functional notes
// - drive a 26-bit address bus for every target type
// - low 16 data lines driven on writes, sampled on reads
// - strap high: upper 16 pins form the high half of 32-bit data
// - upper data half used only for dram and rom transfers in wide mode
// - strap low: upper 16 pins serve as general-purpose port pins
// - panel select low for the whole of each panel access
// - read strobe low whenever reading panel, ram or rom
// - write strobe low whenever writing panel, ram or rom
// - names ending in _n are low-true on both sides
//
// ----------------------------------------------------------------
// access timing, counted in enabled clock edges
// ----------------------------------------------------------------
// edge 0: request taken while req_ready is high
// edge 0 also: address, strobe and select launched; req_ready drops
// memory and isa targets: strobe held for the fixed strobe count
// panel target: select and strobe held until panel_ready is seen high
// one closing cycle keeps the strobe low while read data is sampled
// the edge after it lifts all strobes and pulses resp_valid
// req_ready returns with resp_valid, so requests may run back to back
//
// ----------------------------------------------------------------
// limitations
// ----------------------------------------------------------------
// strap caught once after reset; moving it later has no effect
// upper pins float for the first enabled cycle after reset
// upper read data is zero unless the access is wide dram or rom
// a panel that never answers holds the port; there is no time limit
// isa targets see only the shared read and write strobes here
// one access at a time; writes are not posted
// enable low freezes an access mid-way with its strobes still held
`timescale 1ns/100ps
module system_bus_lcd_mem_port (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic                              clk_en,
  // strap
  input  wire logic                              wide_bus_strap,
  // request port
  input  wire logic                              req_valid,
  input  wire logic                              req_write,
  input  wire logic [1:0]                        req_target,
  input  wire logic [sysbus_pkg::ADDR_W-1:0]     req_addr,
  input  wire logic [sysbus_pkg::DATA_W-1:0]     req_wdata,
  output logic                                   req_ready,
  output logic                                   resp_valid,
  output logic      [sysbus_pkg::DATA_W-1:0]     resp_rdata,
  // general-purpose port on the upper pins
  input  wire logic [sysbus_pkg::HALF_W-1:0]     gpio_out,
  input  wire logic [sysbus_pkg::HALF_W-1:0]     gpio_dir,
  output logic      [sysbus_pkg::HALF_W-1:0]     gpio_in,
  // address and strobes
  output logic      [sysbus_pkg::ADDR_W-1:0]     addr,
  output logic                                   read_n,
  output logic                                   write_n,
  output logic                                   panel_select_n,
  input  wire logic                              panel_ready,
  // low data pins
  input  wire logic [sysbus_pkg::HALF_W-1:0]     data_lo_in,
  output logic      [sysbus_pkg::HALF_W-1:0]     data_lo_out,
  output logic                                   data_lo_oe,
  // upper shared pins
  input  wire logic [sysbus_pkg::HALF_W-1:0]     data_hi_in,
  output logic      [sysbus_pkg::HALF_W-1:0]     data_hi_out,
  output logic      [sysbus_pkg::HALF_W-1:0]     data_hi_oe
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    sysbus_pkg::state_type           fsm;
    logic                            strap_seen;
    logic                            wide;
    logic                            write;
    logic                            use_hi;
    logic [3:0]                      cnt;
    logic [sysbus_pkg::ADDR_W-1:0]   addr;
    logic [sysbus_pkg::DATA_W-1:0]   wdata;
    logic                            read_n;
    logic                            write_n;
    logic                            panel_select_n;
    logic                            data_lo_oe;
    logic                            hi_oe;
    logic                            req_ready;
    logic                            resp_valid;
    logic [sysbus_pkg::DATA_W-1:0]   rdata;
    logic [sysbus_pkg::HALF_W-1:0]   gpio_in;
  } port_state_type;

  port_state_type st_r;
  port_state_type st_nxt;

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // one access at a time; the next request waits in the caller until done
  always_comb begin
    st_nxt            = st_r;
    st_nxt.resp_valid = 1'b0;
    // strap caught once after reset release, so mode never changes mid-run
    if (!st_r.strap_seen) begin
      st_nxt.strap_seen = 1'b1;
      st_nxt.wide       = wide_bus_strap;
    end
    // general-purpose inputs follow the upper pins when narrow
    if (!st_r.wide) begin
      st_nxt.gpio_in = data_hi_in;
    end
    case (st_r.fsm)
      sysbus_pkg::ST_IDLE: begin
        st_nxt.req_ready = st_r.strap_seen;
        if (req_valid && st_r.req_ready) begin
          st_nxt.req_ready = 1'b0;
          st_nxt.write     = req_write;
          st_nxt.addr      = req_addr;
          st_nxt.wdata     = req_wdata;
          st_nxt.use_hi    = st_r.wide && (req_target == sysbus_pkg::TGT_DRAM ||
                                           req_target == sysbus_pkg::TGT_ROM);
          st_nxt.read_n    = req_write;
          st_nxt.write_n   = !req_write;
          st_nxt.data_lo_oe = req_write;
          st_nxt.hi_oe     = req_write && st_r.wide && (req_target == sysbus_pkg::TGT_DRAM ||
                                                        req_target == sysbus_pkg::TGT_ROM);
          st_nxt.cnt       = sysbus_pkg::STROBE_CYC;
          if (req_target == sysbus_pkg::TGT_LCD) begin
            st_nxt.panel_select_n = 1'b0;
            st_nxt.fsm            = sysbus_pkg::ST_PANEL;
          end else begin
            st_nxt.fsm = sysbus_pkg::ST_STROBE;
          end
        end
      end
      sysbus_pkg::ST_STROBE: begin
        // fixed strobe length for memory and isa targets
        if (st_r.cnt <= 4'h1) begin
          st_nxt.fsm = sysbus_pkg::ST_DONE;
        end else begin
          st_nxt.cnt = st_r.cnt - 4'h1;
        end
      end
      sysbus_pkg::ST_PANEL: begin
        // strobes, select and address stay put until the panel is ready
        if (panel_ready) begin
          st_nxt.fsm = sysbus_pkg::ST_DONE;
        end
      end
      sysbus_pkg::ST_DONE: begin
        // sample read data at the trailing edge of the strobe
        if (!st_r.write) begin
          st_nxt.rdata = {st_r.use_hi ? data_hi_in : sysbus_pkg::HALF_RST, data_lo_in};
        end
        st_nxt.read_n         = 1'b1;
        st_nxt.write_n        = 1'b1;
        st_nxt.panel_select_n = 1'b1;
        st_nxt.data_lo_oe     = 1'b0;
        st_nxt.hi_oe          = 1'b0;
        st_nxt.resp_valid     = 1'b1;
        st_nxt.req_ready      = 1'b1;
        st_nxt.fsm            = sysbus_pkg::ST_IDLE;
      end
      default: begin
        st_nxt.fsm = sysbus_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r                <= '0;
      st_r.fsm            <= sysbus_pkg::ST_IDLE;
      st_r.addr           <= sysbus_pkg::ADDR_RST;
      st_r.wdata          <= sysbus_pkg::DATA_RST;
      st_r.rdata          <= sysbus_pkg::DATA_RST;
      st_r.read_n         <= 1'b1;
      st_r.write_n        <= 1'b1;
      st_r.panel_select_n <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // upper pin half
  // ----------------------------------------------------------------
  gpio_half u_gpio_half (
    .clk       (clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .wide_mode (st_nxt.wide),
    .bus_out   (st_nxt.wdata[sysbus_pkg::DATA_W-1:sysbus_pkg::HALF_W]),
    .bus_oe    (st_nxt.hi_oe),
    .gpio_out  (gpio_out),
    .gpio_dir  (gpio_dir & {sysbus_pkg::HALF_W{st_nxt.strap_seen}}),
    .pin_out   (data_hi_out),
    .pin_oe    (data_hi_oe)
  );

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign req_ready      = st_r.req_ready;
  assign resp_valid     = st_r.resp_valid;
  assign resp_rdata     = st_r.rdata;
  assign gpio_in        = st_r.gpio_in;
  assign addr           = st_r.addr;
  assign read_n         = st_r.read_n;
  assign write_n        = st_r.write_n;
  assign panel_select_n = st_r.panel_select_n;
  assign data_lo_out    = st_r.wdata[sysbus_pkg::HALF_W-1:0];
  assign data_lo_oe     = st_r.data_lo_oe;

endmodule : system_bus_lcd_mem_port

// *** testbench/far_side_model.sv ***
// memory, panel and isa targets seen from the port's pins
`timescale 1ns/100ps
module far_side_model (
  // clock and setup
  input  wire logic        clk,
  input  wire logic        wide,
  input  wire logic [2:0]  wait_cyc,
  // device pins
  input  wire logic [25:0] addr,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        panel_select_n,
  input  wire logic [15:0] data_lo_out,
  input  wire logic        data_lo_oe,
  input  wire logic [15:0] data_hi_out,
  input  wire logic [15:0] data_hi_oe,
  output logic             panel_ready,
  output logic      [15:0] data_lo_in,
  output logic      [15:0] data_hi_in,
  output logic      [31:0] wr_seen
);
  logic [2:0]  sel_cnt = 3'h0;
  logic [31:0] last = 32'h0000_0000;
  logic [31:0] pat;
  logic [31:0] ext;
  assign pat = {addr[25:10] ^ 16'h0f0f, addr[15:0] ^ 16'h3c5a};
  // ready only after the chosen wait, and only while selected
  assign panel_ready = !panel_select_n && sel_cnt >= wait_cyc;
  // released bus shows the inverse of its last value, never a stale copy
  assign ext = !read_n ? pat : ~last;
  assign data_lo_in = ext[15:0];
  assign data_hi_in = (data_hi_oe & data_hi_out) | (~data_hi_oe & ext[31:16]);
  // count select cycles, remember read data, capture written words
  always @(posedge clk) begin
    if (!read_n) last <= pat;
    sel_cnt <= panel_select_n ? 3'h0 : (sel_cnt == 3'h7 ? sel_cnt : sel_cnt + 3'h1);
    if (!write_n) wr_seen <= {wide && &data_hi_oe ? data_hi_out : 16'h0000, data_lo_oe ? data_lo_out : 16'h0000};
  end
endmodule : far_side_model

// *** testbench/system_bus_lcd_mem_port_assertions.sv ***
// concurrent checks on the system bus port pins
`timescale 1ns/100ps
module sysbus_port_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // request side
  input wire logic        wide_bus_strap,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_write,
  input wire logic [1:0]  req_target,
  input wire logic [25:0] req_addr,
  input wire logic        resp_valid,
  // pins
  input wire logic [15:0] gpio_out,
  input wire logic [15:0] gpio_dir,
  input wire logic [25:0] addr,
  input wire logic        read_n,
  input wire logic        write_n,
  input wire logic        panel_select_n,
  input wire logic        panel_ready,
  input wire logic        data_lo_oe,
  input wire logic [15:0] data_hi_oe,
  input wire logic [15:0] data_hi_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [1:0] age_r;
  logic       take;
  assign take = req_valid && req_ready;
  // age since reset; the upper pins float for the first cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) age_r <= 2'h0;
    else if (age_r != 2'h3) age_r <= age_r + 2'h1;
  end
  // ------
  // checks
  // ------
  chk_addr_launch: assert property (take |=> addr == $past(req_addr)) else $error("address not launched");
  chk_lo_drive: assert property (!write_n |-> data_lo_oe) else $error("low data not driven");
  chk_wide_write: assert property (wide_bus_strap && take && req_write && !req_target[1]
    |=> (data_hi_oe == 16'hffff) [*3]) else $error("upper half not driven");
  chk_hi_unused: assert property (wide_bus_strap && take && req_target[1]
    |=> (data_hi_oe == 16'h0000) [*3]) else $error("upper half driven for panel or isa");
  chk_gpio_follow: assert property (age_r == 2'h3 && !wide_bus_strap
    |=> data_hi_oe == $past(gpio_dir) && data_hi_out == $past(gpio_out)) else $error("gpio not on pins");
  chk_panel_sel: assert property (take && req_target == 2'h2 |=> !panel_select_n) else $error("no select");
  chk_read_len: assert property ($fell(read_n) && panel_select_n
    |-> !read_n [*3] ##1 read_n) else $error("read strobe length wrong");
  chk_strobe_excl: assert property (read_n || write_n) else $error("both strobes low");
  chk_write_done: assert property ($rose(write_n) |-> resp_valid) else $error("write end without response");
  chk_panel_hold: assert property (!panel_select_n && !panel_ready
    |=> !panel_select_n && $stable(addr)) else $error("panel access left early");
  cov_panel_wait: cover property (!panel_select_n && !panel_ready ##1 panel_ready);
  cov_wide_write: cover property (wide_bus_strap && take && req_write && !req_target[1]);
  cov_narrow_read: cover property (!wide_bus_strap && $fell(read_n));
endmodule : sysbus_port_checker

bind system_bus_lcd_mem_port sysbus_port_checker i_chk (
  .clk(clk), .reset_n(reset_n), .wide_bus_strap(wide_bus_strap), .req_valid(req_valid),
  .req_ready(req_ready), .req_write(req_write), .req_target(req_target), .req_addr(req_addr),
  .resp_valid(resp_valid), .gpio_out(gpio_out), .gpio_dir(gpio_dir), .addr(addr), .read_n(read_n),
  .write_n(write_n), .panel_select_n(panel_select_n), .panel_ready(panel_ready),
  .data_lo_oe(data_lo_oe), .data_hi_oe(data_hi_oe), .data_hi_out(data_hi_out));

// *** testbench/system_bus_lcd_mem_port_bench.sv ***
// self-checking bench for the system bus port
`timescale 1ns/100ps
module system_bus_lcd_mem_port_bench;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        strap = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [1:0]  req_target = 2'h0;
  logic [25:0] req_addr = 26'h000_0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic [15:0] gpio_out = 16'h0000;
  logic [15:0] gpio_dir = 16'h0000;
  logic [2:0]  wait_cyc = 3'h0;
  logic        req_ready, resp_valid, read_n, write_n, panel_select_n, panel_ready, data_lo_oe;
  logic [31:0] resp_rdata, wr_seen;
  logic [25:0] addr;
  logic [15:0] gpio_in, data_lo_in, data_lo_out, data_hi_in, data_hi_out, data_hi_oe;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          seed = 32'hfad214a0;

  always #2 clk = ~clk;

  system_bus_lcd_mem_port i_dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .wide_bus_strap(strap),
    .req_valid(req_valid), .req_write(req_write), .req_target(req_target), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .gpio_out(gpio_out), .gpio_dir(gpio_dir), .gpio_in(gpio_in), .addr(addr), .read_n(read_n),
    .write_n(write_n), .panel_select_n(panel_select_n), .panel_ready(panel_ready), .data_lo_in(data_lo_in),
    .data_lo_out(data_lo_out), .data_lo_oe(data_lo_oe), .data_hi_in(data_hi_in),
    .data_hi_out(data_hi_out), .data_hi_oe(data_hi_oe));

  far_side_model i_far (.clk(clk), .wide(strap), .wait_cyc(wait_cyc), .addr(addr), .read_n(read_n),
    .write_n(write_n), .panel_select_n(panel_select_n), .data_lo_out(data_lo_out), .data_lo_oe(data_lo_oe),
    .data_hi_out(data_hi_out), .data_hi_oe(data_hi_oe), .panel_ready(panel_ready),
    .data_lo_in(data_lo_in), .data_hi_in(data_hi_in), .wr_seen(wr_seen));

  // ------
  // tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // one access, entered at a falling edge; back to back when called again
  task automatic access(input logic [1:0] tgt, input logic wr, input logic [25:0] a, input logic [31:0] wd);
    int   t0;
    int   n;
    logic hi_on;
    hi_on = strap && !tgt[1];
    if (wr) exp_q.push_back({hi_on ? wd[31:16] : 16'h0000, wd[15:0]});
    else exp_q.push_back({hi_on ? a[25:10] ^ 16'h0f0f : 16'h0000, a[15:0] ^ 16'h3c5a});
    req_valid = 1'b1;
    req_write = wr;
    req_target = tgt;
    req_addr = a;
    req_wdata = wd;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    t0 = cyc;
    n = 0;
    while (resp_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    // panel: ready seen after wait_cyc select cycles, then one closing cycle
    if (tgt == 2'h2) check(32'(cyc - t0), 32'(wait_cyc) + 32'h0000_0002);
    else check(32'(cyc - t0), 32'(sysbus_pkg::STROBE_CYC) + 32'h0000_0001);
    check(wr ? wr_seen : resp_rdata, exp_q.pop_front());
    check({6'h00, addr}, {6'h00, a});
  endtask : access

  // timeout guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ------
  // main sequence: wide pass, then narrow pass after a second reset
  // ------
  initial begin
    for (int m = 0; m < 2; m++) begin
      strap = (m == 0);
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 32; i++) begin
        wait_cyc = 3'($random(seed));
        gpio_dir = 16'($random(seed));
        gpio_out = 16'($random(seed));
        if (i < 8) access(2'(i), 1'(i >> 2), 26'($random(seed)), 32'($random(seed)));
        else access(2'($random(seed)), 1'($random(seed)), 26'($random(seed)), 32'($random(seed)));
        if (!strap) check({16'h0000, gpio_in & gpio_dir}, {16'h0000, gpio_out & gpio_dir});
      end
    end
    print_verdict();
  end
endmodule : system_bus_lcd_mem_port_bench
